// ===== hdl/cmf_ctrl.sv
// CAN controller core: modes, acceptance filtering, transmit order, flags.
// Assumes a bit-level protocol engine beside it and an APB master.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Timer sync clears the timer on reception into buffer 0.
// - Listen-only: no acknowledge; accept only frames others acknowledged.
// - Next transmit: highest-priority or lowest-index pending buffer.
// - Local priority adds buffer priority, only under the priority scheme.
// - Each buffer holds a transmit priority of 0 to 7.
// - Warning interrupts need global and own enables.
// - Bus-off, error, wakeup, warning flags: own enables and clears.
// - Reading the error and status register clears error bits.
// - One global acceptance mask serves buffers 0 through 13.
// - Mask one: bit must match; zero: don't-care.
// - Buffer 14 uses its own acceptance mask.
// - Buffer 15 uses its own acceptance mask.
// - Individual masking replaces global and dedicated masks.
// - Reading the timer unlocks every locked buffer.
// - A field sets the last buffer index in use, 0 to 15.
// - Per-buffer flags and enables; read all, clear any subset.
// - Received bits sampled once or three times.
// - An 8-bit divisor, 0 to 255, makes the quantum.
// - Jump width 1 to 4 quanta; segments 1 to 8 quanta stored as 0 to 7.
// - Engine clock is the oscillator or the bus clock.
// - Halt entered or left on request, acknowledged by a flag.
// - Low-power acknowledge flag; not-ready clears once ready.
// - Self-wakeup leaves doze on bus activity, raw or filtered.
// - A control allows receiving own transmitted frames.
// - Supervisor mode admits only privileged configuration access.
module cmf_ctrl
    import cmf_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [2:0] pprot_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic can_rx_in,
    output logic can_tx_out,
    input wire logic eng_tx_in,
    output logic eng_rx_out,
    input wire cmf_rx_frame_t rx_frame_in,
    output cmf_tx_req_t tx_req_out,
    input wire logic tx_busy_in,
    input wire logic tx_done_in,
    input wire logic [3:0] tx_done_index_in,
    input wire logic [3:0] err_bits_in,
    input wire logic bus_off_event_in,
    input wire logic error_event_in,
    input wire logic tx_warn_event_in,
    input wire logic rx_warn_event_in,
    output cmf_timing_t timing_out,
    output logic quantum_tick_out,
    output logic status_irq_out,
    output logic buffer_irq_out
);
    logic [31:0] modcfg;
    logic [31:0] timing;
    logic [15:0] timer;
    logic [31:0] gmask;
    logic [31:0] m14;
    logic [31:0] m15;
    logic [4:0] irq_flags;
    logic [3:0] err_bits;
    logic [15:0] imask;
    logic [15:0] iflag;
    logic [15:0] locked;
    logic [3:0] code [CMF_NUM_MB];
    logic [2:0] prio [CMF_NUM_MB];
    logic [CMF_ID_W-1:0] mb_id [CMF_NUM_MB];
    logic [31:0] imsk [CMF_NUM_MB];
    logic halt_ack;
    logic lp_ack;
    logic soft_rst;
    logic [2:0] rx_sync;
    logic rx_level;
    logic [3:0] low_cnt;
    logic [7:0] qcnt;
    logic pready_q;

    // Bus access decode; a transfer completes on the edge with pready high
    logic acc;
    logic wr;
    logic rd;
    logic mb_sel;
    logic imsk_sel;
    logic [3:0] sel_idx;
    logic priv_bad;
    logic unmapped;
    logic rst;
    assign acc = psel_in && penable_in && pready_q;
    assign mb_sel = paddr_in[11:8] == CMF_A_MB_BASE[11:8] && paddr_in[7] == 1'b0;
    assign imsk_sel = paddr_in[11:8] == CMF_A_IMSK_BASE[11:8] && paddr_in[7:6] == 2'b00;
    assign sel_idx = mb_sel ? paddr_in[6:3] : paddr_in[5:2];
    assign unmapped = !(mb_sel || imsk_sel || paddr_in <= CMF_A_IFLAG) || paddr_in[1:0] != 2'b00;
    // Only the control registers below the timer are guarded
    assign priv_bad = modcfg[CMF_B_SUPV] && !pprot_in[0] && paddr_in < CMF_A_TIMER;
    assign wr = acc && pwrite_in && !unmapped && !priv_bad;
    assign rd = acc && !pwrite_in && !unmapped && !priv_bad;
    // Soft reset returns every control field to its reset value
    assign rst = reset_in || soft_rst;

    // Acceptance filter: lowest matching receive buffer wins
    logic rx_hit;
    logic [3:0] rx_idx;
    logic rx_ok;
    always_comb begin
        logic [31:0] m;
        m = '0;
        rx_hit = 1'b0;
        rx_idx = '0;
        rx_ok = rx_frame_in.valid && !halt_ack && !lp_ack && !modcfg[CMF_B_DIS]
            && (!timing[CMF_B_LISTEN] || rx_frame_in.acked_by_other)
            && (modcfg[CMF_B_SELFRX] || !rx_frame_in.self_sent);
        for (int i = CMF_NUM_MB - 1; i >= 0; i--) begin
            if (modcfg[CMF_B_IRMQ]) begin
                m = imsk[i];
            end else if (i == 14) begin
                m = m14;
            end else if (i == 15) begin
                m = m15;
            end else begin
                m = gmask;
            end
            if (rx_ok && 4'(i) <= modcfg[CMF_B_LAST+:4] && !locked[i]
                && (code[i] == CMF_C_RX_EMPTY || code[i] == CMF_C_RX_FULL)
                && ((rx_frame_in.id ^ mb_id[i]) & m[CMF_ID_W-1:0]) == '0) begin
                rx_hit = 1'b1;
                rx_idx = 4'(i);
            end
        end
    end

    // Transmit order: smallest key among pending buffers
    logic tx_hit;
    logic [3:0] tx_idx;
    always_comb begin
        logic [31:0] key;
        logic [31:0] best;
        key = '0;
        best = '1;
        tx_hit = 1'b0;
        tx_idx = '0;
        for (int i = 0; i < CMF_NUM_MB; i++) begin
            if (timing[CMF_B_LOWBUF]) begin
                key = 32'(i);
            end else if (modcfg[CMF_B_LPRIO]) begin
                key = {prio[i], mb_id[i]};
            end else begin
                key = {3'h0, mb_id[i]};
            end
            if (code[i] == CMF_C_TX_DATA && 4'(i) <= modcfg[CMF_B_LAST+:4]
                && (!tx_hit || key < best)) begin
                tx_hit = 1'b1;
                tx_idx = 4'(i);
                best = key;
            end
        end
    end

    // Abort is honoured unless the engine is already sending that buffer
    logic abort_now;
    assign abort_now = wr && mb_sel && !paddr_in[2] && modcfg[CMF_B_ABTEN]
        && pwdata_in[3:0] == CMF_C_TX_ABORT && code[sel_idx] == CMF_C_TX_DATA
        && !(tx_busy_in && tx_req_out.index == sel_idx);

    // Per-buffer events that raise a flag
    logic [15:0] mb_set;
    always_comb begin
        mb_set = '0;
        if (rx_hit) begin
            mb_set[rx_idx] = 1'b1;
        end
        if (tx_done_in) begin
            mb_set[tx_done_index_in] = 1'b1;
        end
        if (abort_now) begin
            mb_set[sel_idx] = 1'b1;
        end
    end

    // Configuration registers and soft reset request
    always_ff @(posedge clk_in) begin
        if (rst) begin
            modcfg <= '0;
            timing <= '0;
            gmask <= CMF_MASK_RST;
            m14 <= CMF_MASK_RST;
            m15 <= CMF_MASK_RST;
            imask <= '0;
            soft_rst <= 1'b0;
        end else begin
            if (wr && paddr_in == CMF_A_MODCFG) begin
                modcfg[15:0] <= pwdata_in[15:0];
                soft_rst <= pwdata_in[CMF_B_SRST] && !lp_ack;
            end
            if (wr && paddr_in == CMF_A_TIMING) begin
                timing[29:0] <= pwdata_in[29:0];
            end
            if (wr && paddr_in == CMF_A_GMASK) begin
                gmask <= pwdata_in;
            end
            if (wr && paddr_in == CMF_A_M14) begin
                m14 <= pwdata_in;
            end
            if (wr && paddr_in == CMF_A_M15) begin
                m15 <= pwdata_in;
            end
            if (wr && paddr_in == CMF_A_IMASK) begin
                imask <= pwdata_in[15:0];
            end
            // Bus activity in doze clears the doze request itself
            if (lp_ack && modcfg[CMF_B_SWAKE] && (modcfg[CMF_B_WFILT]
                ? low_cnt == CMF_WAKE_FILT : !rx_level)) begin
                modcfg[CMF_B_DOZE] <= 1'b0;
            end
        end
    end

    // Mode acknowledges follow requests one cycle later
    always_ff @(posedge clk_in) begin
        if (rst) begin
            halt_ack <= 1'b0;
            lp_ack <= 1'b0;
        end else begin
            halt_ack <= modcfg[CMF_B_HALT];
            lp_ack <= modcfg[CMF_B_DOZE] || modcfg[CMF_B_DIS];
        end
    end

    // Receive pin synchroniser; the third stage confirms a change
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rx_sync <= 3'b111;
            rx_level <= 1'b1;
            low_cnt <= '0;
        end else begin
            rx_sync <= {rx_sync[1:0], can_rx_in};
            if (rx_sync[1] == rx_sync[2]) begin
                rx_level <= rx_sync[2];
            end
            // Filtered wake source needs a dominant level that persists
            if (rx_level) begin
                low_cnt <= '0;
            end else if (low_cnt != CMF_WAKE_FILT) begin
                low_cnt <= low_cnt + 4'h1;
            end
        end
    end

    // Pin routing; loopback keeps the bus recessive and feeds the engine itself
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            can_tx_out <= 1'b1;
            eng_rx_out <= 1'b1;
        end else begin
            can_tx_out <= timing[CMF_B_LOOP] ? 1'b1 : eng_tx_in;
            eng_rx_out <= timing[CMF_B_LOOP] ? eng_tx_in : rx_level;
        end
    end

    // Quantum prescaler counts divisor plus one engine clocks
    always_ff @(posedge clk_in) begin
        if (rst) begin
            qcnt <= '0;
            quantum_tick_out <= 1'b0;
        end else begin
            quantum_tick_out <= qcnt == timing[CMF_B_DIV+:8];
            qcnt <= qcnt == timing[CMF_B_DIV+:8] ? 8'h00 : qcnt + 8'h01;
        end
    end

    // Bit timing handed to the engine
    always_ff @(posedge clk_in) begin
        if (rst) begin
            timing_out <= '0;
        end else begin
            timing_out.resync_jump_width <= timing[CMF_B_RJW+:2];
            timing_out.prop <= timing[CMF_B_PROP+:3];
            timing_out.ps1 <= timing[CMF_B_PS1+:3];
            timing_out.ps2 <= timing[CMF_B_PS2+:3];
            timing_out.three_samples <= timing[CMF_B_SMP3];
            timing_out.bus_clock <= timing[CMF_B_CLKSEL];
            timing_out.ack_enable <= !timing[CMF_B_LISTEN] && !halt_ack;
        end
    end

    // Free-running timer
    always_ff @(posedge clk_in) begin
        if (rst) begin
            timer <= '0;
        end else if (timing[CMF_B_TSYNC] && rx_hit && rx_idx == 4'h0) begin
            timer <= '0;
        end else if (!halt_ack) begin
            timer <= timer + 16'h0001;
        end
    end

    // Message buffers; reading a control word locks the buffer
    always_ff @(posedge clk_in) begin
        if (rst) begin
            for (int i = 0; i < CMF_NUM_MB; i++) begin
                code[i] <= CMF_C_RX_OFF;
                prio[i] <= '0;
                mb_id[i] <= '0;
                imsk[i] <= CMF_MASK_RST;
            end
            locked <= '0;
        end else begin
            if (tx_done_in) begin
                code[tx_done_index_in] <= CMF_C_TX_OFF;
            end
            if (rx_hit) begin
                code[rx_idx] <= CMF_C_RX_FULL;
            end
            if (wr && mb_sel && !paddr_in[2]) begin
                code[sel_idx] <= abort_now ? CMF_C_TX_OFF : pwdata_in[3:0];
                prio[sel_idx] <= pwdata_in[CMF_B_PRIO+:3];
            end
            if (wr && mb_sel && paddr_in[2]) begin
                mb_id[sel_idx] <= pwdata_in[CMF_ID_W-1:0];
            end
            if (wr && imsk_sel) begin
                imsk[sel_idx] <= pwdata_in;
            end
            if (rd && paddr_in == CMF_A_TIMER) begin
                locked <= '0;
            end else if (rd && mb_sel && !paddr_in[2]) begin
                locked[sel_idx] <= 1'b1;
            end
        end
    end

    // Buffer flags: write one to clear, a same-cycle event wins
    always_ff @(posedge clk_in) begin
        if (rst) begin
            iflag <= '0;
        end else if (wr && paddr_in == CMF_A_IFLAG) begin
            iflag <= (iflag & ~pwdata_in[15:0]) | mb_set;
        end else begin
            iflag <= iflag | mb_set;
        end
    end

    // Status flags and error bits; set wins over clear
    logic [4:0] ev;
    assign ev = {rx_warn_event_in, tx_warn_event_in, bus_off_event_in, error_event_in,
        lp_ack && !modcfg[CMF_B_DOZE] && modcfg[CMF_B_SWAKE]};
    always_ff @(posedge clk_in) begin
        if (rst) begin
            irq_flags <= '0;
            err_bits <= '0;
        end else begin
            if (wr && paddr_in == CMF_A_ERRST) begin
                irq_flags <= (irq_flags & ~pwdata_in[4:0]) | ev;
            end else begin
                irq_flags <= irq_flags | ev;
            end
            if (rd && paddr_in == CMF_A_ERRST) begin
                err_bits <= err_bits_in;
            end else begin
                err_bits <= err_bits | err_bits_in;
            end
        end
    end

    // Interrupt lines; warnings need both global and own enables
    logic [4:0] ie;
    assign ie = timing[CMF_B_IE+:5];
    always_ff @(posedge clk_in) begin
        if (rst) begin
            status_irq_out <= 1'b0;
            buffer_irq_out <= 1'b0;
        end else begin
            status_irq_out <= |(irq_flags[2:0] & ie[2:0])
                || (modcfg[CMF_B_WRNEN] && |(irq_flags[4:3] & ie[4:3]));
            buffer_irq_out <= |(iflag & imask);
        end
    end

    // Transmit request toward the engine, held off in halt and low power
    always_ff @(posedge clk_in) begin
        if (rst) begin
            tx_req_out <= '0;
        end else begin
            tx_req_out.valid <= tx_hit && !halt_ack && !lp_ack;
            tx_req_out.index <= tx_idx;
            tx_req_out.id <= mb_id[tx_idx];
        end
    end

    // Read mux
    logic [31:0] rdata;
    always_comb begin
        rdata = '0;
        if (mb_sel) begin
            rdata = paddr_in[2] ? 32'(mb_id[sel_idx])
                : {25'h0, prio[sel_idx], code[sel_idx]};
        end else if (imsk_sel) begin
            rdata = imsk[sel_idx];
        end else begin
            unique case (paddr_in)
                CMF_A_MODCFG: rdata = {13'h0, lp_ack, halt_ack,
                    modcfg[CMF_B_DIS] || lp_ack || halt_ack, modcfg[15:0]};
                CMF_A_TIMING: rdata = timing;
                CMF_A_TIMER: rdata = {16'h0, timer};
                CMF_A_GMASK: rdata = gmask;
                CMF_A_M14: rdata = m14;
                CMF_A_M15: rdata = m15;
                CMF_A_ERRST: rdata = {20'h0, err_bits, 3'h0, irq_flags};
                CMF_A_IMASK: rdata = {16'h0, imask};
                CMF_A_IFLAG: rdata = {16'h0, iflag};
                default: rdata = '0;
            endcase
        end
    end

    // APB answer: no wait state, data and error registered
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            pready_q <= 1'b0;
            prdata_out <= '0;
            pslverr_out <= 1'b0;
        end else begin
            pready_q <= psel_in && !penable_in;
            prdata_out <= (unmapped || priv_bad) ? 32'h00000000 : rdata;
            pslverr_out <= psel_in && !penable_in && (unmapped || priv_bad);
        end
    end
    assign pready_out = pready_q;
endmodule
`default_nettype wire

// ===== inc/cmf_pkg.sv
// Shared constants and carriers of the CAN mode, filter and buffer controller.
// Assumes one 100 MHz clock and an APB master with 32-bit data.
package cmf_pkg;
    localparam int CMF_NUM_MB = 16;
    localparam int CMF_ID_W = 29;
    // Register byte offsets
    localparam logic [11:0] CMF_A_MODCFG = 12'h000;
    localparam logic [11:0] CMF_A_TIMING = 12'h004;
    localparam logic [11:0] CMF_A_TIMER = 12'h008;
    localparam logic [11:0] CMF_A_GMASK = 12'h00C;
    localparam logic [11:0] CMF_A_M14 = 12'h010;
    localparam logic [11:0] CMF_A_M15 = 12'h014;
    localparam logic [11:0] CMF_A_ERRST = 12'h018;
    localparam logic [11:0] CMF_A_IMASK = 12'h01C;
    localparam logic [11:0] CMF_A_IFLAG = 12'h020;
    localparam logic [11:0] CMF_A_MB_BASE = 12'h100;
    localparam logic [11:0] CMF_A_IMSK_BASE = 12'h200;
    // Configuration register field positions
    localparam int CMF_B_DIS = 0;
    localparam int CMF_B_DOZE = 1;
    localparam int CMF_B_HALT = 2;
    localparam int CMF_B_SRST = 3;
    localparam int CMF_B_SWAKE = 4;
    localparam int CMF_B_WFILT = 5;
    localparam int CMF_B_SUPV = 6;
    localparam int CMF_B_WRNEN = 7;
    localparam int CMF_B_SELFRX = 8;
    localparam int CMF_B_IRMQ = 9;
    localparam int CMF_B_LPRIO = 10;
    localparam int CMF_B_ABTEN = 11;
    localparam int CMF_B_LAST = 12;
    localparam int CMF_B_NRDY = 16;
    localparam int CMF_B_HACK = 17;
    localparam int CMF_B_LPACK = 18;
    // Timing register field positions
    localparam int CMF_B_DIV = 0;
    localparam int CMF_B_RJW = 8;
    localparam int CMF_B_PROP = 10;
    localparam int CMF_B_PS1 = 13;
    localparam int CMF_B_PS2 = 16;
    localparam int CMF_B_SMP3 = 19;
    localparam int CMF_B_LISTEN = 20;
    localparam int CMF_B_LOOP = 21;
    localparam int CMF_B_TSYNC = 22;
    localparam int CMF_B_LOWBUF = 23;
    localparam int CMF_B_CLKSEL = 24;
    localparam int CMF_B_IE = 25;
    // Interrupt flag order in the error and status register
    localparam int CMF_F_WAKE = 0;
    localparam int CMF_F_ERR = 1;
    localparam int CMF_F_BOFF = 2;
    localparam int CMF_F_TWRN = 3;
    localparam int CMF_F_RWRN = 4;
    localparam int CMF_B_EBITS = 8;
    // Buffer control word: code in [3:0], transmit priority in [6:4]
    localparam int CMF_B_PRIO = 4;
    localparam logic [3:0] CMF_C_RX_OFF = 4'h0;
    localparam logic [3:0] CMF_C_RX_FULL = 4'h2;
    localparam logic [3:0] CMF_C_RX_EMPTY = 4'h4;
    localparam logic [3:0] CMF_C_TX_OFF = 4'h8;
    localparam logic [3:0] CMF_C_TX_ABORT = 4'h9;
    localparam logic [3:0] CMF_C_TX_DATA = 4'hC;
    localparam logic [31:0] CMF_MASK_RST = 32'hFFFFFFFF;
    localparam logic [3:0] CMF_WAKE_FILT = 4'h8;

    typedef struct packed {
        logic valid;
        logic [CMF_ID_W-1:0] id;
        logic acked_by_other;
        logic self_sent;
    } cmf_rx_frame_t;

    typedef struct packed {
        logic valid;
        logic [3:0] index;
        logic [CMF_ID_W-1:0] id;
    } cmf_tx_req_t;

    typedef struct packed {
        logic [1:0] resync_jump_width;
        logic [2:0] prop;
        logic [2:0] ps1;
        logic [2:0] ps2;
        logic three_samples;
        logic bus_clock;
        logic ack_enable;
    } cmf_timing_t;
endpackage

// ===== verif/cmf_ctrl_asserts.sv
// Port-level checker of the CAN controller core.
// Assumes one clock domain; bound to every cmf_ctrl instance.
`timescale 1ns/1ps
`default_nettype none
module cmf_ctrl_asserts
    import cmf_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic can_tx_out,
    input wire logic eng_rx_out,
    input wire logic status_irq_out,
    input wire logic buffer_irq_out
);
    default clocking dc @(posedge clk_in);
    endclocking
    // Setup cycle; its access phase must answer exactly one cycle later
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    property p_ans; disable iff (reset_in) s_setup |=> pready_out; endproperty
    a_ans: assert property (p_ans) else $error("no ready after setup");
    property p_idle; disable iff (reset_in) !psel_in || penable_in |=> !pready_out; endproperty
    a_idle: assert property (p_idle) else $error("ready without setup");
    property p_err; disable iff (reset_in) pslverr_out |-> pready_out; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_rec; disable iff (reset_in) pslverr_out |-> prdata_out == 32'h0; endproperty
    a_rec: assert property (p_rec) else $error("refused read data not zero");
    property p_unal; disable iff (reset_in) s_setup ##0 paddr_in[1:0] != 2'h0 |=> pslverr_out;
    endproperty
    a_unal: assert property (p_unal) else $error("unaligned access accepted");
    property p_hole;
        disable iff (reset_in) s_setup ##0 paddr_in inside {[12'h024:12'h0FC]} |=> pslverr_out;
    endproperty
    a_hole: assert property (p_hole) else $error("unmapped access accepted");
    // Reset leaves the bus recessive, pready low and both interrupts low
    property p_rst; reset_in |=> can_tx_out && eng_rx_out && !pready_out; endproperty
    a_rst: assert property (p_rst) else $error("bad pin levels after reset");
    property p_rirq; reset_in |=> !status_irq_out && !buffer_irq_out; endproperty
    a_rirq: assert property (p_rirq) else $error("interrupt high after reset");
endmodule
bind cmf_ctrl cmf_ctrl_asserts u_cmf_ctrl_asserts (.*);
`default_nettype wire

// ===== verif/cmf_can_node.sv
// Model of the other nodes on the bus, seen through a transceiver.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module cmf_can_node
    import cmf_pkg::*;
(
    input wire logic clk_in,
    input wire logic can_tx_in,
    output logic can_rx_out,
    output cmf_rx_frame_t frame_out,
    output logic [3:0] err_out,
    output logic [3:0] evt_out
);
    // Wired-AND bus with the others recessive, so the pin follows our own drive
    assign can_rx_out = can_tx_in;
    initial {frame_out, err_out, evt_out} = '0;
    // A frame that another node acknowledged, as a one-cycle pulse
    task automatic send(input logic [28:0] id);
        frame_out <= '{valid: 1'b1, id: id, acked_by_other: 1'b1, self_sent: 1'b0};
        @(posedge clk_in);
        frame_out <= '0;
    endtask
    // Error events and error bits for one cycle
    task automatic pulse(input logic [3:0] ev, input logic [3:0] eb);
        evt_out <= ev;
        err_out <= eb;
        @(posedge clk_in);
        {evt_out, err_out} <= 8'h00;
    endtask
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench of the CAN controller core, random with a fixed seed.
// Assumes the node model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb
    import cmf_pkg::*;
;
    logic clk_in, reset_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, err, hit;
    logic can_rx_in, can_tx_out, eng_tx_in, eng_rx_out, tx_busy_in, tx_done_in;
    logic bus_off_event_in, error_event_in, tx_warn_event_in, rx_warn_event_in;
    logic quantum_tick_out, status_irq_out, buffer_irq_out;
    logic [2:0] pprot_in;
    logic [3:0] tx_done_index_in, err_bits_in;
    logic [11:0] paddr_in, a;
    logic [31:0] pwdata_in, prdata_out, rd, t;
    logic [28:0] m, bid, rid;
    cmf_rx_frame_t rx_frame_in;
    cmf_tx_req_t tx_req_out;
    cmf_timing_t timing_out;
    int n_fail, num_checks, cyc, k, b;
    cmf_ctrl u_cmf_ctrl (.*);
    cmf_can_node u_cmf_can_node (.clk_in, .can_tx_in(can_tx_out), .can_rx_out(can_rx_in),
        .frame_out(rx_frame_in), .err_out(err_bits_in),
        .evt_out({bus_off_event_in, error_event_in, tx_warn_event_in, rx_warn_event_in}));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // Hang guard; the run needs about three hundred cycles
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    // Expected timing outputs of a timing word
    function automatic cmf_timing_t exp_tim(input logic [31:0] v);
        return '{resync_jump_width: v[9:8], prop: v[12:10], ps1: v[15:13], ps2: v[18:16],
            three_samples: v[19], bus_clock: v[24], ack_enable: !v[20]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= ad;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        {psel_in, penable_in} <= 2'b00;
        repeat (2) @(posedge clk_in);
    endtask
    task automatic print_verdict;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, tx_busy_in, tx_done_in,
            tx_done_index_in} = '0;
        eng_tx_in = 1'b1;
        pprot_in = 3'h1;
        reset_in = 1'b1;
        t = $urandom(32'hE035);
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        // Mask reset value, then refused addresses
        apb(1'b0, CMF_A_M15, 32'h0);
        chk(rd, CMF_MASK_RST);
        apb(1'b1, 12'h040, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b0, 12'h006, 32'h0);
        chk(32'(err), 32'h1);
        // Random bit timing; a short divisor keeps the tick period measurable
        repeat (4) begin
            t = $urandom & 32'h01FFFF07;
            apb(1'b1, CMF_A_TIMING, t);
            chk(32'(timing_out), 32'(exp_tim(t)));
            for (k = 0; k < 300 && quantum_tick_out !== 1'b1; k++) @(posedge clk_in);
            for (k = 1; k < 300; k++) begin
                @(posedge clk_in);
                if (quantum_tick_out === 1'b1) break;
            end
            chk(k, t[7:0] + 1);
        end
        // Buffer 3 uses the global mask, 14 and 15 their own; hits, then misses
        apb(1'b1, CMF_A_MODCFG, 32'h0000F000);
        apb(1'b1, CMF_A_IMASK, 32'h0000FFFF);
        for (int j = 0; j < 6; j++) begin
            b = (j % 3 == 0) ? 3 : 13 + j % 3;
            a = CMF_A_MB_BASE + 12'(8 * b);
            m = 29'($urandom);
            bid = 29'($urandom);
            rid = bid ^ ((j < 3) ? 29'($urandom) & ~m : m & (~m + 29'h1));
            hit = ((rid ^ bid) & m) == 29'h0;
            apb(1'b1, (b == 3) ? CMF_A_GMASK : CMF_A_M14 + 12'(4 * (b - 14)), 32'(m));
            apb(1'b1, a + 12'h4, 32'(bid));
            apb(1'b1, a, 32'(CMF_C_RX_EMPTY));
            u_cmf_can_node.send(rid);
            repeat (3) @(posedge clk_in);
            chk(32'(buffer_irq_out), 32'(hit));
            apb(1'b0, CMF_A_IFLAG, 32'h0);
            chk(rd, 32'(hit) << b);
            apb(1'b1, CMF_A_IFLAG, 32'h0000FFFF);
            apb(1'b1, a, 32'(CMF_C_RX_OFF));
        end
        // Error bits clear when read; the bus-off flag drives the status interrupt
        apb(1'b1, CMF_A_TIMING, 32'h1 << (CMF_B_IE + CMF_F_BOFF));
        u_cmf_can_node.pulse(4'h8, 4'h5);
        apb(1'b0, CMF_A_ERRST, 32'h0);
        chk(32'(status_irq_out), 32'h1);
        chk(rd, (32'h5 << CMF_B_EBITS) | (32'h1 << CMF_F_BOFF));
        apb(1'b1, CMF_A_ERRST, 32'h1 << CMF_F_BOFF);
        apb(1'b0, CMF_A_ERRST, 32'h0);
        chk(rd, 32'h0);
        chk(32'(status_irq_out), 32'h0);
        // Transmit warning interrupt needs the global warning enable as well
        apb(1'b1, CMF_A_TIMING, 32'h1 << (CMF_B_IE + CMF_F_TWRN));
        for (int w = 0; w < 2; w++) begin
            apb(1'b1, CMF_A_MODCFG, 32'(w) << CMF_B_WRNEN);
            u_cmf_can_node.pulse(4'h2, 4'h0);
            repeat (2) @(posedge clk_in);
            chk(32'(status_irq_out), 32'(w));
        end
        // Identifier 0 in buffer 5 beats identifier 1 in buffer 2, until lowest index rules
        apb(1'b1, CMF_A_MODCFG, 32'h0000F000);
        apb(1'b1, 12'h114, 32'h1);
        apb(1'b1, 12'h110, 32'(CMF_C_TX_DATA));
        apb(1'b1, 12'h128, 32'(CMF_C_TX_DATA));
        chk(32'(tx_req_out.index), 32'h5);
        apb(1'b1, CMF_A_TIMING, 32'h1 << CMF_B_LOWBUF);
        chk(32'(tx_req_out.index), 32'h2);
        print_verdict();
    end
endmodule
`default_nettype wire
